/* File: rtl/asp_regs.vh */
// Summary of operation
// - Start trigger runs transfer and master clock.
// - Stop halts transfer, clock, then flags stopped.
// - Receive flag every buffer-size words received.
// - Transmit flag every buffer-size words fetched; a word paired with a receive word is not fetched.
// - Receive flag coincides with pointer shadow copy.
// - Transmit flag coincides with pointer shadow copy.
// - Five pin selects route the five signals.
// - Pins owned only while module enabled.
// - Owned pins get direction from role, mode; MCK pin from MCKEN.
// - One buffer size serves both directions.
// - Buffer size counts 32-bit words.
// - Memory touched only for enabled directions.
// - Mono transmit repeats sample on both halves.
// - In master mode, frame rate is master clock over ratio.
`ifndef ASP_REGS_VH
`define ASP_REGS_VH
`define ASP_OFF_START   12'h000
`define ASP_OFF_STOP    12'h004
`define ASP_OFF_SUBST   12'h080
`define ASP_OFF_SUBSP   12'h084
`define ASP_OFF_EVRX    12'h104
`define ASP_OFF_EVSTP   12'h108
`define ASP_OFF_EVTX    12'h114
`define ASP_OFF_PUBRX   12'h184
`define ASP_OFF_PUBSTP  12'h188
`define ASP_OFF_PUBTX   12'h194
`define ASP_OFF_IRQMSK  12'h300
`define ASP_OFF_INTSET  12'h304
`define ASP_OFF_INTCLR  12'h308
`define ASP_OFF_ENABLE  12'h500
`define ASP_OFF_MODE    12'h504
`define ASP_OFF_RXEN    12'h508
`define ASP_OFF_TXEN    12'h50c
`define ASP_OFF_MCKEN   12'h510
`define ASP_OFF_MCKFREQ 12'h514
`define ASP_OFF_RATIO   12'h518
`define ASP_OFF_SWIDTH  12'h51c
`define ASP_OFF_ALIGN   12'h520
`define ASP_OFF_FORMAT  12'h524
`define ASP_OFF_CHAN    12'h528
`define ASP_OFF_RXPTR   12'h538
`define ASP_OFF_TXPTR   12'h540
`define ASP_OFF_MAXCNT  12'h550
`define ASP_OFF_PSEL0   12'h560
`define ASP_OFF_PSEL4   12'h570
`define ASP_BIT_RX      1
`define ASP_BIT_STP     2
`define ASP_BIT_TX      5
`define ASP_CONN_BIT    31
`define ASP_RST_PSEL    32'hffffffff
`define ASP_RST_MCKEN   32'h00000001
`define ASP_RST_MCKFREQ 32'h00000004
`define ASP_RST_RATIO   32'h00000100
`define ASP_RST_TXEN    32'h00000001
`define ASP_SW_8        2'h0
`define ASP_SW_16       2'h1
`define ASP_CH_STEREO   2'h0
`define ASP_CH_LEFT     2'h1
`define ASP_RESP_OK     2'h0
`define ASP_RESP_ERR    2'h2
`endif

/* File: rtl/asp_ctrl.v */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "asp_regs.vh"
module asp_ctrl (
  // System
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write
  input  wire [11:0] s_awaddr,
  input  wire        s_awvalid,
  output wire        s_awready,
  input  wire [31:0] s_wdata,
  input  wire [3:0]  s_wstrb,
  input  wire        s_wvalid,
  output wire        s_wready,
  output reg  [1:0]  s_bresp,
  output reg         s_bvalid,
  input  wire        s_bready,
  // AXI4-Lite read
  input  wire [11:0] s_araddr,
  input  wire        s_arvalid,
  output wire        s_arready,
  output reg  [31:0] s_rdata,
  output reg  [1:0]  s_rresp,
  output reg         s_rvalid,
  input  wire        s_rready,
  // Pins
  input  wire [31:0] pin_in,
  output reg  [31:0] pin_out,
  output reg  [31:0] pin_oe,
  output reg  [31:0] pin_own,
  // Formatter side
  input  wire        ser_out_bit,
  output reg         ser_in_bit_q,
  output reg         tx_repeat_q,
  // Memory requests
  output reg  [31:0] dma_addr_q,
  output reg         dma_rd_q,
  output reg         dma_wr_q,
  // Interrupt
  output wire        irq
);

  reg  [31:0] ptr_q [0:4];
  reg  [31:0] psel_q [0:4];
  reg  [31:0] irq_mask_q;
  reg  [31:0] enable_q;
  reg  [31:0] mode_q;
  reg  [31:0] rxen_q;
  reg  [31:0] txen_q;
  reg  [31:0] mcken_q;
  reg  [31:0] mckfreq_q;
  reg  [31:0] ratio_q;
  reg  [31:0] swidth_q;
  reg  [31:0] align_q;
  reg  [31:0] format_q;
  reg  [31:0] chan_q;
  reg  [31:0] rxptr_q;
  reg  [31:0] txptr_q;
  reg  [31:0] maxcnt_q;
  reg         ev_rx_q;
  reg         ev_stp_q;
  reg         ev_tx_q;
  reg         run_q;
  reg         stop_pend_q;
  reg  [11:0] aw_addr_q;
  reg         aw_v_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_v_q;
  reg  [31:0] mclk_cnt_q;
  reg         mclk_q;
  reg  [31:0] fr_cnt_q;
  reg         lr_q;
  reg  [2:0]  lr_sync_q;
  reg         lr_s_q;
  reg  [2:0]  sd_sync_q;
  reg         half_q;
  reg  [1:0]  rx_smp_q;
  reg  [1:0]  tx_smp_q;
  reg  [31:0] rx_off_q;
  reg  [31:0] tx_off_q;
  reg  [31:0] rx_sh_q;
  reg  [31:0] tx_sh_q;
  reg  [31:0] rd_d;
  reg  [1:0]  rresp_d;
  reg  [31:0] pout_d;
  reg  [31:0] poe_d;
  reg  [31:0] pown_d;
  integer     i;
  integer     j;

  wire        wr_go = aw_v_q & w_v_q & ~s_bvalid;
  wire [31:0] wd    = w_data_q;
  wire        wt    = w_strb_q[0] & wd[0];
  wire        slave = mode_q[0];
  wire        en    = enable_q[0];

  assign s_awready = ~aw_v_q & ~s_bvalid;
  assign s_wready  = ~w_v_q & ~s_bvalid;
  assign s_arready = ~s_rvalid;

  function [31:0] wm;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wm[8*k +: 8] = s[k] ? d[8*k +: 8] : old[8*k +: 8];
      end
    end
  endfunction

  // Samples packed in one 32-bit word, less one.
  function [1:0] spw_m1;
    input [1:0] sw;
    begin
      case (sw)
        `ASP_SW_8:  spw_m1 = 2'h3;
        `ASP_SW_16: spw_m1 = 2'h1;
        default:    spw_m1 = 2'h0;
      endcase
    end
  endfunction

  function hit;
    input [31:0] ps;
    input [4:0]  p;
    begin
      hit = ~ps[`ASP_CONN_BIT] & (ps[4:0] == p);
    end
  endfunction

  function last_word;
    input [31:0] off;
    input [31:0] mx;
    begin
      last_word = (off + 32'h1) >= mx;
    end
  endfunction

  wire wr_start = wr_go && aw_addr_q == `ASP_OFF_START && wt;
  wire wr_stop  = wr_go && aw_addr_q == `ASP_OFF_STOP && wt;
  wire starting = wr_start & en & ~run_q;

  // Register file and AXI write channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_q    <= 1'b0;
      aw_addr_q <= 12'h000;
      w_v_q     <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `ASP_RESP_OK;
      for (i = 0; i < 5; i = i + 1) begin
        ptr_q[i]  <= 32'h00000000;
        psel_q[i] <= `ASP_RST_PSEL;
      end
      irq_mask_q <= 32'h00000000;
      enable_q  <= 32'h00000000;
      mode_q    <= 32'h00000000;
      rxen_q    <= 32'h00000000;
      txen_q    <= `ASP_RST_TXEN;
      mcken_q   <= `ASP_RST_MCKEN;
      mckfreq_q <= `ASP_RST_MCKFREQ;
      ratio_q   <= `ASP_RST_RATIO;
      swidth_q  <= 32'h00000001;
      align_q   <= 32'h00000000;
      format_q  <= 32'h00000000;
      chan_q    <= 32'h00000000;
      rxptr_q   <= 32'h00000000;
      txptr_q   <= 32'h00000000;
      maxcnt_q  <= 32'h00000000;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_v_q    <= 1'b1;
        aw_addr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_v_q    <= 1'b1;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_v_q   <= 1'b0;
        w_v_q    <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= `ASP_RESP_OK;
        case (aw_addr_q)
          `ASP_OFF_START, `ASP_OFF_STOP: begin
          end
          `ASP_OFF_EVRX, `ASP_OFF_EVSTP, `ASP_OFF_EVTX: begin
          end
          `ASP_OFF_SUBST:   ptr_q[0]  <= wm(ptr_q[0], wd, w_strb_q);
          `ASP_OFF_SUBSP:   ptr_q[1]  <= wm(ptr_q[1], wd, w_strb_q);
          `ASP_OFF_PUBRX:   ptr_q[2]  <= wm(ptr_q[2], wd, w_strb_q);
          `ASP_OFF_PUBSTP:  ptr_q[3]  <= wm(ptr_q[3], wd, w_strb_q);
          `ASP_OFF_PUBTX:   ptr_q[4]  <= wm(ptr_q[4], wd, w_strb_q);
          `ASP_OFF_IRQMSK:  irq_mask_q <= wm(irq_mask_q, wd, w_strb_q);
          `ASP_OFF_INTSET:  irq_mask_q <= irq_mask_q | wm(32'h0, wd, w_strb_q);
          `ASP_OFF_INTCLR:  irq_mask_q <= irq_mask_q & ~wm(32'h0, wd, w_strb_q);
          `ASP_OFF_ENABLE:  enable_q  <= wm(enable_q, wd, w_strb_q);
          `ASP_OFF_MODE:    mode_q    <= wm(mode_q, wd, w_strb_q);
          `ASP_OFF_RXEN:    rxen_q    <= wm(rxen_q, wd, w_strb_q);
          `ASP_OFF_TXEN:    txen_q    <= wm(txen_q, wd, w_strb_q);
          `ASP_OFF_MCKEN:   mcken_q   <= wm(mcken_q, wd, w_strb_q);
          `ASP_OFF_MCKFREQ: mckfreq_q <= wm(mckfreq_q, wd, w_strb_q);
          `ASP_OFF_RATIO:   ratio_q   <= wm(ratio_q, wd, w_strb_q);
          `ASP_OFF_SWIDTH:  swidth_q  <= wm(swidth_q, wd, w_strb_q);
          `ASP_OFF_ALIGN:   align_q   <= wm(align_q, wd, w_strb_q);
          `ASP_OFF_FORMAT:  format_q  <= wm(format_q, wd, w_strb_q);
          `ASP_OFF_CHAN:    chan_q    <= wm(chan_q, wd, w_strb_q);
          `ASP_OFF_RXPTR:   rxptr_q   <= wm(rxptr_q, wd, w_strb_q);
          `ASP_OFF_TXPTR:   txptr_q   <= wm(txptr_q, wd, w_strb_q);
          `ASP_OFF_MAXCNT:  maxcnt_q  <= wm(maxcnt_q, wd, w_strb_q);
          12'h560, 12'h564, 12'h568, 12'h56c, `ASP_OFF_PSEL4: begin
            psel_q[aw_addr_q[4:2]] <= wm(psel_q[aw_addr_q[4:2]], wd, w_strb_q);
          end
          default: s_bresp <= `ASP_RESP_ERR;
        endcase
      end
    end
  end

  // Read decode.
  always @* begin
    rd_d    = 32'h00000000;
    rresp_d = `ASP_RESP_OK;
    case (s_araddr)
      `ASP_OFF_START, `ASP_OFF_STOP: rd_d = 32'h00000000;
      `ASP_OFF_SUBST:   rd_d = ptr_q[0];
      `ASP_OFF_SUBSP:   rd_d = ptr_q[1];
      `ASP_OFF_PUBRX:   rd_d = ptr_q[2];
      `ASP_OFF_PUBSTP:  rd_d = ptr_q[3];
      `ASP_OFF_PUBTX:   rd_d = ptr_q[4];
      `ASP_OFF_EVRX:    rd_d = {31'h0, ev_rx_q};
      `ASP_OFF_EVSTP:   rd_d = {31'h0, ev_stp_q};
      `ASP_OFF_EVTX:    rd_d = {31'h0, ev_tx_q};
      `ASP_OFF_IRQMSK, `ASP_OFF_INTSET, `ASP_OFF_INTCLR: rd_d = irq_mask_q;
      `ASP_OFF_ENABLE:  rd_d = enable_q;
      `ASP_OFF_MODE:    rd_d = mode_q;
      `ASP_OFF_RXEN:    rd_d = rxen_q;
      `ASP_OFF_TXEN:    rd_d = txen_q;
      `ASP_OFF_MCKEN:   rd_d = mcken_q;
      `ASP_OFF_MCKFREQ: rd_d = mckfreq_q;
      `ASP_OFF_RATIO:   rd_d = ratio_q;
      `ASP_OFF_SWIDTH:  rd_d = swidth_q;
      `ASP_OFF_ALIGN:   rd_d = align_q;
      `ASP_OFF_FORMAT:  rd_d = format_q;
      `ASP_OFF_CHAN:    rd_d = chan_q;
      `ASP_OFF_RXPTR:   rd_d = rxptr_q;
      `ASP_OFF_TXPTR:   rd_d = txptr_q;
      `ASP_OFF_MAXCNT:  rd_d = maxcnt_q;
      12'h560, 12'h564, 12'h568, 12'h56c, `ASP_OFF_PSEL4: begin
        rd_d = psel_q[s_araddr[4:2]];
      end
      default: rresp_d = `ASP_RESP_ERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h00000000;
      s_rresp  <= `ASP_RESP_OK;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_d;
      s_rresp  <= rresp_d;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // Master clock divider: the output toggles every divider count of system cycles.
  wire mclk_tick = run_q && (mclk_cnt_q + 32'h1 >= mckfreq_q);
  wire mclk_rise = mclk_tick & ~mclk_q;

  always @(posedge aclk) begin
    if (!aresetn || !run_q) begin
      mclk_cnt_q <= 32'h00000000;
      mclk_q     <= 1'b0;
    end else if (mclk_tick) begin
      mclk_cnt_q <= 32'h00000000;
      mclk_q     <= ~mclk_q;
    end else begin
      mclk_cnt_q <= mclk_cnt_q + 32'h1;
    end
  end

  // Master frame clock: one half frame is half the ratio in mck periods.
  always @(posedge aclk) begin
    if (!aresetn || !run_q || slave) begin
      fr_cnt_q <= 32'h00000000;
      lr_q     <= 1'b0;
    end else if (mclk_rise) begin
      if (fr_cnt_q + 32'h1 >= {1'b0, ratio_q[31:1]}) begin
        fr_cnt_q <= 32'h00000000;
        lr_q     <= ~lr_q;
      end else begin
        fr_cnt_q <= fr_cnt_q + 32'h1;
      end
    end
  end

  // Slave frame clock and serial input from pins. The mux sits ahead
  // of the first flop so the chain itself stays a clean synchroniser.
  always @(posedge aclk) begin
    if (!aresetn) begin
      lr_sync_q    <= 3'h0;
      sd_sync_q    <= 3'h0;
      lr_s_q       <= 1'b0;
      ser_in_bit_q <= 1'b0;
    end else begin
      lr_sync_q <= {lr_sync_q[1:0], pin_in[psel_q[2][4:0]]};
      sd_sync_q <= {sd_sync_q[1:0], pin_in[psel_q[3][4:0]]};
      if (lr_sync_q[1] == lr_sync_q[2]) begin
        lr_s_q <= lr_sync_q[2];
      end
      if (sd_sync_q[1] == sd_sync_q[2]) begin
        ser_in_bit_q <= sd_sync_q[2];
      end
    end
  end

  wire lr_lvl   = slave ? lr_s_q : lr_q;
  wire half_new = run_q & (lr_lvl != half_q);
  // Level low on the frame clock marks the left half.
  wire left     = ~lr_lvl;
  wire mono     = chan_q[1:0] != `ASP_CH_STEREO;
  wire rx_take  = half_new && rxen_q[0] &&
                  (!mono || (left == (chan_q[1:0] == `ASP_CH_LEFT)));
  // Mono transmit fetches on the left half only and repeats it.
  wire tx_take  = half_new && txen_q[0] && (!mono || left);
  wire [1:0] spw = spw_m1(swidth_q[1:0]);
  wire rx_word  = rx_take && rx_smp_q == spw;
  wire tx_word  = tx_take && tx_smp_q == spw;
  wire rx_wrap  = rx_word && last_word(rx_off_q, maxcnt_q);
  wire tx_wrap  = tx_word && last_word(tx_off_q, maxcnt_q);
  wire rx_upd   = starting & rxen_q[0] | rx_wrap;
  wire tx_upd   = starting & txen_q[0] | tx_wrap;

  // Run control, sample counting and pointer double buffering.
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_q       <= 1'b0;
      stop_pend_q <= 1'b0;
      half_q      <= 1'b0;
      rx_smp_q    <= 2'h0;
      tx_smp_q    <= 2'h0;
      rx_off_q    <= 32'h00000000;
      tx_off_q    <= 32'h00000000;
      rx_sh_q     <= 32'h00000000;
      tx_sh_q     <= 32'h00000000;
      tx_repeat_q <= 1'b0;
      dma_addr_q  <= 32'h00000000;
      dma_rd_q    <= 1'b0;
      dma_wr_q    <= 1'b0;
    end else begin
      stop_pend_q <= wr_stop;
      dma_rd_q    <= 1'b0;
      dma_wr_q    <= 1'b0;
      if (wr_stop) begin
        run_q <= 1'b0;
      end else if (starting) begin
        run_q    <= 1'b1;
        half_q   <= lr_lvl;
        rx_smp_q <= 2'h0;
        tx_smp_q <= 2'h0;
        rx_off_q <= 32'h00000000;
        tx_off_q <= 32'h00000000;
      end else if (half_new) begin
        half_q      <= lr_lvl;
        tx_repeat_q <= mono & ~left;
      end
      if (rx_take && !starting) begin
        rx_smp_q <= rx_word ? 2'h0 : rx_smp_q + 2'h1;
      end
      if (tx_take && !starting) begin
        tx_smp_q <= tx_word ? 2'h0 : tx_smp_q + 2'h1;
      end
      if (rx_word && !starting) begin
        dma_wr_q   <= 1'b1;
        dma_addr_q <= rx_sh_q + {rx_off_q[29:0], 2'b00};
        rx_off_q   <= rx_wrap ? 32'h00000000 : rx_off_q + 32'h1;
      end else if (tx_word && !starting) begin
        dma_rd_q   <= 1'b1;
        dma_addr_q <= tx_sh_q + {tx_off_q[29:0], 2'b00};
        tx_off_q   <= tx_wrap ? 32'h00000000 : tx_off_q + 32'h1;
      end
      if (rx_upd) begin
        rx_sh_q <= rxptr_q;
      end
      if (tx_upd) begin
        tx_sh_q <= txptr_q;
      end
    end
  end

  // When a receive and a transmit word finish in the same cycle only
  // the receive request is issued; with both directions in stereo they always pair so.
  wire wr_ev = wr_go & w_strb_q[0] & ~wd[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      ev_rx_q  <= 1'b0;
      ev_stp_q <= 1'b0;
      ev_tx_q  <= 1'b0;
    end else begin
      // A hardware set wins over a software clear in the same cycle.
      ev_rx_q  <= rx_upd | ev_rx_q &
                  ~(wr_ev && aw_addr_q == `ASP_OFF_EVRX);
      ev_tx_q  <= tx_upd | ev_tx_q &
                  ~(wr_ev && aw_addr_q == `ASP_OFF_EVTX);
      ev_stp_q <= stop_pend_q | ev_stp_q &
                  ~(wr_ev && aw_addr_q == `ASP_OFF_EVSTP);
    end
  end

  assign irq = ev_rx_q & irq_mask_q[`ASP_BIT_RX] |
               ev_stp_q & irq_mask_q[`ASP_BIT_STP] |
               ev_tx_q & irq_mask_q[`ASP_BIT_TX];

  // Pin ownership and direction.
  always @* begin
    pout_d = 32'h00000000;
    poe_d  = 32'h00000000;
    pown_d = 32'h00000000;
    for (j = 0; j < 32; j = j + 1) begin
      if (en) begin
        if (hit(psel_q[0], j[4:0])) begin
          pown_d[j] = 1'b1;
          poe_d[j]  = mcken_q[0];
          pout_d[j] = mclk_q;
        end
        if (hit(psel_q[1], j[4:0])) begin
          pown_d[j] = 1'b1;
          poe_d[j]  = ~slave;
          pout_d[j] = mclk_q;
        end
        if (hit(psel_q[2], j[4:0])) begin
          pown_d[j] = 1'b1;
          poe_d[j]  = ~slave;
          pout_d[j] = lr_q;
        end
        if (hit(psel_q[3], j[4:0])) begin
          pown_d[j] = 1'b1;
        end
        if (hit(psel_q[4], j[4:0])) begin
          pown_d[j] = 1'b1;
          poe_d[j]  = 1'b1;
          pout_d[j] = ser_out_bit & run_q;
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 32'h00000000;
      pin_oe  <= 32'h00000000;
      pin_own <= 32'h00000000;
    end else begin
      pin_out <= pout_d;
      pin_oe  <= poe_d;
      pin_own <= pown_d;
    end
  end

endmodule

/* File: sim/asp_ctrl_properties.sv */
`timescale 1ns/1ns
module asp_ctrl_props (
  // System
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire        s_awvalid,
  input wire        s_awready,
  input wire        s_wvalid,
  input wire        s_wready,
  input wire [1:0]  s_bresp,
  input wire        s_bvalid,
  input wire        s_bready,
  input wire        s_arvalid,
  input wire        s_arready,
  input wire [31:0] s_rdata,
  input wire        s_rvalid,
  input wire        s_rready,
  // Pins and memory
  input wire [31:0] pin_oe,
  input wire [31:0] pin_own,
  input wire        tx_repeat_q,
  input wire [31:0] dma_addr_q,
  input wire        dma_rd_q,
  input wire        dma_wr_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_b_hold;
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");

  property p_b_answer;
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write never answered");

  property p_r_hold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");

  property p_r_answer;
    s_arvalid && s_arready |=> s_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read never answered");

  property p_oe_owned;
    (pin_oe & ~pin_own) == 32'h0;
  endproperty
  a_oe_owned: assert property (p_oe_owned) else $error("unowned pin driven");

  property p_pin_count;
    $countones(pin_own) <= 5;
  endproperty
  a_pin_count: assert property (p_pin_count) else $error("too many pins owned");

  property p_dma_excl;
    !(dma_rd_q && dma_wr_q);
  endproperty
  a_dma_excl: assert property (p_dma_excl) else $error("read and write together");

  property p_dma_pulse;
    dma_rd_q || dma_wr_q |=> !dma_rd_q && !dma_wr_q;
  endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("memory request too long");

  property p_dma_align;
    dma_rd_q || dma_wr_q |-> dma_addr_q[1:0] == 2'h0;
  endproperty
  a_dma_align: assert property (p_dma_align) else $error("unaligned memory word");

  property p_mono_fetch;
    tx_repeat_q |-> !dma_rd_q;
  endproperty
  a_mono_fetch: assert property (p_mono_fetch) else $error("fetch on repeated half");
endmodule

bind asp_ctrl asp_ctrl_props asp_ctrl_props_i (
  .aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
  .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
  .s_rvalid(s_rvalid), .s_rready(s_rready), .pin_oe(pin_oe), .pin_own(pin_own),
  .tx_repeat_q(tx_repeat_q), .dma_addr_q(dma_addr_q), .dma_rd_q(dma_rd_q),
  .dma_wr_q(dma_wr_q));

/* File: sim/asp_codec_model.sv */
`timescale 1ns/1ns
module asp_codec_model (
  // System
  input  wire         aclk,
  input  wire         slow,
  // Pins
  input  wire  [31:0] pin_out,
  input  wire  [31:0] pin_oe,
  input  wire  [4:0]  lr_pin,
  input  wire  [4:0]  din_pin,
  output logic [31:0] pin_in
);
  logic [31:0] lfsr_q = 32'h1;
  logic [1:0]  lr_q = 2'h0;
  logic        bit_q = 1'b0;
  // A new serial bit follows each frame clock change, a cycle later when slow.
  always @(posedge aclk) begin
    lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    lr_q <= {lr_q[0], pin_out[lr_pin]};
    if (slow ? lr_q[1] != lr_q[0] : lr_q[0] != pin_out[lr_pin])
      bit_q <= lfsr_q[7];
  end
  // Undriven pins other than the data pin carry free-running LFSR bits.
  always @* begin
    pin_in = lfsr_q;
    pin_in[din_pin] = bit_q;
    pin_in = (pin_in & ~pin_oe) | (pin_out & pin_oe);
  end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`include "asp_regs.vh"
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_awaddr = 12'h0;
  logic        s_awvalid = 1'b0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_wvalid = 1'b0;
  logic        s_bready = 1'b0;
  logic [11:0] s_araddr = 12'h0;
  logic        s_arvalid = 1'b0;
  logic        s_rready = 1'b0;
  logic        ser_out_bit = 1'b0;
  logic        slow = 1'b0;
  logic [4:0]  pins [5] = '{5'h0, 5'h1, 5'h2, 5'h3, 5'h4};
  wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  wire         ser_in_bit_q, tx_repeat_q, dma_rd_q, dma_wr_q, irq;
  wire  [1:0]  s_bresp, s_rresp;
  wire  [31:0] s_rdata, pin_in, pin_out, pin_oe, pin_own, dma_addr_q;
  int          failures = 0;
  int          compares = 0;
  logic [31:0] q_wr [$];
  logic [31:0] q_rd [$];
  logic [31:0] rd_d, p0;
  logic [1:0]  rd_r, wr_r;
  logic [11:0] fl, pr;
  logic        lv, so;
  int          cnt, n, m, i, n0, hf;
  logic [11:0] ra [8] = '{`ASP_OFF_ENABLE, `ASP_OFF_TXEN, `ASP_OFF_MCKEN, `ASP_OFF_MCKFREQ,
                          `ASP_OFF_RATIO, `ASP_OFF_PSEL0, `ASP_OFF_MAXCNT, `ASP_OFF_IRQMSK};
  logic [31:0] rv [8] = '{32'h0, `ASP_RST_TXEN, `ASP_RST_MCKEN, `ASP_RST_MCKFREQ,
                          `ASP_RST_RATIO, `ASP_RST_PSEL, 32'h0, 32'h0};

  asp_ctrl asp_ctrl_i (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_own(pin_own), .ser_out_bit(ser_out_bit),
    .ser_in_bit_q(ser_in_bit_q), .tx_repeat_q(tx_repeat_q), .dma_addr_q(dma_addr_q),
    .dma_rd_q(dma_rd_q), .dma_wr_q(dma_wr_q), .irq(irq));
  asp_codec_model asp_codec_model_i (
    .aclk(aclk), .slow(slow), .pin_out(pin_out), .pin_oe(pin_oe),
    .lr_pin(pins[2]), .din_pin(pins[3]), .pin_in(pin_in));

  initial forever #2 aclk = ~aclk;

  always @(posedge aclk) begin
    ser_out_bit <= 1'($urandom);
    if (dma_wr_q === 1'b1) q_wr.push_back(dma_addr_q);
    if (dma_rd_q === 1'b1) q_rd.push_back(dma_addr_q);
  end

  function automatic logic [31:0] pm(input int k);
    pm = 32'h1 << pins[k];
  endfunction

  task end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A wait that runs out is a mismatch and closes the run.
  task tmo;
    chk(32'h0, 32'h1);
    end_of_test;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    int k;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      wr_r = s_bresp;
      if (s_bvalid === 1'b1) break;
    end
    if (k == 50) tmo;
  endtask

  task rd(input logic [11:0] a);
    int k;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      rd_d = s_rdata;
      rd_r = s_rresp;
      if (s_rvalid === 1'b1) break;
    end
    if (k == 50) tmo;
  endtask

  initial begin
    void'($urandom(37159));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (n = 0; n < 8; n++) begin
      rd(ra[n]);
      chk(rd_d, rv[n]);
    end
    rd(12'h7fc);
    chk({30'h0, rd_r}, {30'h0, `ASP_RESP_ERR});
    wr(12'h7fc, 32'h0);
    chk({30'h0, wr_r}, {30'h0, `ASP_RESP_ERR});
    $display("test reset_values done");
    wr(`ASP_OFF_INTSET, 32'h24);
    wr(`ASP_OFF_INTSET, 32'h0);
    wr(`ASP_OFF_INTCLR, 32'h4);
    rd(`ASP_OFF_IRQMSK);
    chk(rd_d, 32'h20);
    chk({31'h0, irq}, 32'h0);
    $display("test irq_mask done");
    n0 = $urandom_range(26);
    for (i = 0; i < 5; i++) begin
      pins[i] <= 5'(n0 + i);
      wr(`ASP_OFF_PSEL0 + 12'(4 * i), 32'(n0 + i));
    end
    for (m = 0; m < 2; m++) begin
      wr(`ASP_OFF_MODE, 32'(m));
      wr(`ASP_OFF_ENABLE, 32'h1);
      repeat (2) @(posedge aclk);
      chk(pin_own, pm(0) | pm(1) | pm(2) | pm(3) | pm(4));
      chk(pin_oe, pm(0) | pm(4) | (m ? 32'h0 : pm(1) | pm(2)));
      wr(`ASP_OFF_ENABLE, 32'h0);
      repeat (2) @(posedge aclk);
      chk(pin_own | pin_oe, 32'h0);
    end
    $display("test pins done");
    wr(`ASP_OFF_MODE, 32'h0);
    wr(`ASP_OFF_MCKFREQ, 32'h1);
    wr(`ASP_OFF_RATIO, 32'h10);
    for (m = 0; m < 2; m++) begin
      p0 = 32'h20000000 | (32'($urandom_range(255)) << 2);
      cnt = $urandom_range(4, 2);
      fl = m ? `ASP_OFF_EVTX : `ASP_OFF_EVRX;
      pr = m ? `ASP_OFF_TXPTR : `ASP_OFF_RXPTR;
      wr(`ASP_OFF_RXEN, 32'(1 - m));
      wr(`ASP_OFF_TXEN, 32'(m));
      wr(`ASP_OFF_CHAN, 32'(m));
      wr(`ASP_OFF_SWIDTH, 32'(2 - m));
      wr(pr, p0);
      wr(`ASP_OFF_MAXCNT, 32'(cnt));
      wr(`ASP_OFF_IRQMSK, m ? 32'h20 : 32'h2);
      wr(`ASP_OFF_ENABLE, 32'h1);
      slow <= m[0];
      q_wr.delete();
      q_rd.delete();
      wr(`ASP_OFF_START, 32'h1);
      rd(fl);
      chk(rd_d, 32'h1);
      chk({31'h0, irq}, 32'h1);
      lv = pin_out[pins[0]];
      so = ser_out_bit;
      @(posedge aclk);
      chk({31'h0, pin_out[pins[0]]}, {31'h0, ~lv});
      chk({31'h0, pin_out[pins[4]]}, {31'h0, so});
      wr(pr, p0 + 32'h400);
      wr(fl, 32'h0);
      rd(fl);
      chk(rd_d, 32'h0);
      if (m == 0) begin
        lv = pin_out[pins[2]];
        for (n = 0; n < 200 && pin_out[pins[2]] === lv; n++) @(posedge aclk);
        if (n == 200) tmo;
        lv = pin_out[pins[2]];
        for (hf = 0; hf < 200 && pin_out[pins[2]] === lv; hf++) @(posedge aclk);
        // Half frame is ratio/2 master clock periods of two cycles each.
        chk(32'(hf), 32'h10);
        // The codec bit settles well inside the half frame it follows.
        repeat (8) @(posedge aclk);
        chk({31'h0, ser_in_bit_q}, {31'h0, pin_in[pins[3]]});
      end
      for (n = 0; n < 3000 && q_wr.size() + q_rd.size() < 2 * cnt; n++) @(posedge aclk);
      if (n == 3000) tmo;
      rd(fl);
      chk(rd_d, 32'h1);
      for (n = 0; n < 2 * cnt; n++)
        chk(m ? q_rd[n] : q_wr[n], p0 + 32'(4 * (n % cnt)) + (n < cnt ? 32'h0 : 32'h400));
      chk(32'(m ? q_wr.size() : q_rd.size()), 32'h0);
      wr(`ASP_OFF_STOP, 32'h1);
      rd(`ASP_OFF_EVSTP);
      chk(rd_d, 32'h1);
      n = q_wr.size() + q_rd.size();
      repeat (100) @(posedge aclk);
      chk({31'h0, pin_out[pins[0]]}, 32'h0);
      chk(32'(q_wr.size() + q_rd.size()), 32'(n));
      wr(`ASP_OFF_EVSTP, 32'h0);
      wr(fl, 32'h0);
      wr(`ASP_OFF_ENABLE, 32'h0);
      $display("test stream %0d done", m);
    end
    end_of_test;
  end
endmodule
